/* inc/ecx_consts.vh */
// Contract
// - Release number register reads fixed 20h; writes do not change it.
// - Frame adjust field is bits 5..0, read/write, resets to 32.
// - Microframe period is 59488 plus sixteen times the adjust value.
// - A newly written adjust value sets the start-of-frame counter period.
// - Port wake mask is 16-bit read/write, resets to 0007h, not acted on.
// - Wake mask bits 15..1 each stand for one downstream port.
// - Wake mask contents never alter any controller operation.
// - Power capability structure at pointer 34h with fixed member offsets; only the dword at DCh is decoded, later members answer no hit.
// - Capability identifier byte reads 01h and is read-only.
// - Only one capability list entry carries the power identifier.
// - Capabilities pointer reads DCh.
// - Next-item pointer reads 00h, ending the capability list.
`ifndef ECX_CONSTS_VH
`define ECX_CONSTS_VH
`define ECX_OFF_CAP_PTR     8'h34
`define ECX_OFF_RELEASE     8'h60
`define ECX_OFF_FRAME_ADJ   8'h61
`define ECX_OFF_WAKE_LO     8'h62
`define ECX_OFF_WAKE_HI     8'h63
`define ECX_CAP_BASE        8'hDC
`define ECX_PM_ID_OFS       8'h00
`define ECX_PM_NEXT_OFS     8'h01
`define ECX_PM_CAP_OFS      8'h02
`define ECX_PM_CSR_OFS      8'h04
`define ECX_PM_BSE_OFS      8'h06
`define ECX_PM_DATA_OFS     8'h07
`define ECX_RELEASE_VAL     8'h20
`define ECX_FRAME_ADJ_RST   6'h20
`define ECX_FRAME_ADJ_MSB   5
`define ECX_WAKE_RST        16'h0007
`define ECX_PM_ID_VAL       8'h01
`define ECX_NEXT_PTR_VAL    8'h00
`define ECX_FRAME_BASE      16'hE860
`define ECX_FRAME_STEP_SH   4
`endif

/* rtl/ecx_frame_timer.v */
`timescale 1ns/10ps
`include "ecx_consts.vh"
// Microframe timer; counts one step per tick of the high-speed bit-time enable
module ecx_frame_timer
(
  input  wire        mclk_i,
  input  wire        sys_rst_i,
  input  wire        bit_tick_i,
  input  wire [5:0]  frame_adj_i,
  output wire [15:0] period_o,
  output reg         sof_o
);
  reg  [15:0] count;
  assign period_o = `ECX_FRAME_BASE + {6'h00, frame_adj_i, 4'h0};
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      count <= 16'h0000;
      sof_o <= 1'b0;
    end
    else
    begin
      sof_o <= 1'b0;
      if (bit_tick_i)
      begin
        if (count >= period_o - 16'h0001)
        begin
          count <= 16'h0000;
          sof_o <= 1'b1;
        end
        else
          count <= count + 16'h0001;
      end
    end
  end
endmodule

/* rtl/ecx_cfg_extras.v */
`timescale 1ns/10ps
`include "ecx_consts.vh"
// EHCI-specific configuration bytes plus power capability header
module ecx_cfg_extras
(
  input  wire        mclk_i,
  input  wire        sys_rst_i,
  input  wire        cfg_rd_i,
  input  wire        cfg_wr_i,
  input  wire [7:0]  cfg_addr_i,
  input  wire [3:0]  cfg_be_i,
  input  wire [31:0] cfg_wdata_i,
  input  wire        bit_tick_i,
  output reg  [31:0] cfg_rdata_o,
  output reg         cfg_hit_o,
  output wire [5:0]  frame_adj_o,
  output wire [15:0] frame_period_o,
  output wire        sof_o
);

  // ==========================================
  // Storage and decode nets
  // ==========================================
  reg  [5:0]  frame_adj;
  reg  [15:0] wake_mask;
  reg  [31:0] next_rdata;
  reg         next_hit;
  wire        any_access;
  wire        sel_cap_ptr;
  wire        sel_ext;
  wire        sel_pm_hdr;
  wire        ext_wr;
  wire        adj_wr;
  wire        wake_lo_wr;
  wire        wake_hi_wr;
  wire [7:0]  adj_byte;
  wire [7:0]  wake_lo_byte;
  wire [7:0]  wake_hi_byte;
  wire [31:0] ext_word;
  wire [31:0] ptr_word;
  wire [31:0] hdr_word;

  // ==========================================
  // Helper functions
  // ==========================================
  // Dword compare; the two low address bits only pick a byte lane
  function dword_match;
    input [7:0] addr;
    input [7:0] base;
    begin
      dword_match = (addr[7:2] == base[7:2]);
    end
  endfunction

  // Byte enable that belongs to one byte offset
  function lane_en;
    input [3:0] be;
    input [7:0] addr;
    begin
      case (addr[1:0])
        2'b00:   lane_en = be[0];
        2'b01:   lane_en = be[1];
        2'b10:   lane_en = be[2];
        default: lane_en = be[3];
      endcase
    end
  endfunction

  // Write data byte that belongs to one byte offset
  function [7:0] lane_byte;
    input [31:0] word;
    input [7:0]  addr;
    begin
      case (addr[1:0])
        2'b00:   lane_byte = word[7:0];
        2'b01:   lane_byte = word[15:8];
        2'b10:   lane_byte = word[23:16];
        default: lane_byte = word[31:24];
      endcase
    end
  endfunction

  // ==========================================
  // Address decode
  // ==========================================
  assign any_access  = cfg_rd_i | cfg_wr_i;
  assign sel_cap_ptr = dword_match(cfg_addr_i, `ECX_OFF_CAP_PTR);
  assign sel_ext     = dword_match(cfg_addr_i, `ECX_OFF_RELEASE);
  assign sel_pm_hdr  = dword_match(cfg_addr_i, `ECX_CAP_BASE + `ECX_PM_ID_OFS);

  // ==========================================
  // Byte lane write strobes
  // ==========================================
  assign ext_wr     = cfg_wr_i & sel_ext;
  assign adj_wr     = ext_wr & lane_en(cfg_be_i, `ECX_OFF_FRAME_ADJ);
  assign wake_lo_wr = ext_wr & lane_en(cfg_be_i, `ECX_OFF_WAKE_LO);
  assign wake_hi_wr = ext_wr & lane_en(cfg_be_i, `ECX_OFF_WAKE_HI);

  // Lane bytes are picked by offset so a dword write may touch any mix of them
  assign adj_byte     = lane_byte(cfg_wdata_i, `ECX_OFF_FRAME_ADJ);
  assign wake_lo_byte = lane_byte(cfg_wdata_i, `ECX_OFF_WAKE_LO);
  assign wake_hi_byte = lane_byte(cfg_wdata_i, `ECX_OFF_WAKE_HI);

  // ==========================================
  // Frame length adjust register
  // ==========================================
  // Only bits 5..0 are stored; bits 7..6 read back as zero whatever is written
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      frame_adj <= `ECX_FRAME_ADJ_RST;
    end
    else if (adj_wr)
    begin
      frame_adj <= adj_byte[`ECX_FRAME_ADJ_MSB:0];
    end
  end

  // ==========================================
  // Port wake mask register
  // ==========================================
  // wake mask storage
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      wake_mask <= `ECX_WAKE_RST;
    end
    else
    begin
      if (wake_lo_wr)
        wake_mask[7:0] <= wake_lo_byte;
      if (wake_hi_wr)
        wake_mask[15:8] <= wake_hi_byte;
    end
  end

  // ==========================================
  // Read words
  // ==========================================
  // Fixed fields come straight from constants so no flop can corrupt them
  // fixed release byte
  assign ext_word = {wake_mask, 2'b00, frame_adj, `ECX_RELEASE_VAL};
  assign ptr_word = {24'h00_0000, `ECX_CAP_BASE};
  assign hdr_word = {16'h0000, `ECX_NEXT_PTR_VAL, `ECX_PM_ID_VAL};

  // ==========================================
  // Read decode
  // ==========================================
  // Words past the header are left unmapped, so they answer no hit
  // single power entry
  always @*
  begin
    next_rdata = 32'h0000_0000;
    next_hit   = 1'b0;
    if (sel_cap_ptr)
    begin
      next_rdata = ptr_word;
      next_hit   = 1'b1;
    end
    else if (sel_ext)
    begin
      next_rdata = ext_word;
      next_hit   = 1'b1;
    end
    else if (sel_pm_hdr)
    begin
      next_rdata = hdr_word;
      next_hit   = 1'b1;
    end
  end

  // ==========================================
  // Registered answer
  // ==========================================
  // Read data falls back to zero between reads so a stale word never lingers
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      cfg_rdata_o <= 32'h0000_0000;
      cfg_hit_o   <= 1'b0;
    end
    else
    begin
      cfg_rdata_o <= cfg_rd_i ? next_rdata : 32'h0000_0000;
      cfg_hit_o   <= any_access & next_hit;
    end
  end

  assign frame_adj_o = frame_adj;

  // ==========================================
  // Microframe timer
  // ==========================================
  // live adjust drives timer
  // wake mask not routed here
  // The timer sees a new adjust at once; a frame in progress ends on the new length
  ecx_frame_timer u_timer
  (
    .mclk_i      (mclk_i),
    .sys_rst_i   (sys_rst_i),
    .bit_tick_i  (bit_tick_i),
    .frame_adj_i (frame_adj),
    .period_o    (frame_period_o),
    .sof_o       (sof_o)
  );
endmodule

/* verification/ecx_cfg_extras_properties.sv */
`timescale 1ns/10ps
module ecx_cfg_props
(
  input wire mclk_i,
  input wire sys_rst_i,
  input wire cfg_rd_i,
  input wire cfg_wr_i,
  input wire [7:0] cfg_addr_i,
  input wire [3:0] cfg_be_i,
  input wire [31:0] cfg_wdata_i,
  input wire [31:0] cfg_rdata_o,
  input wire [5:0] frame_adj_o,
  input wire [15:0] frame_period_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);
  wire [5:0] w = cfg_wdata_i[13:8];
  wire r = cfg_rd_i && cfg_addr_i[7:2] == 6'h18;
  wire u = cfg_wr_i && cfg_addr_i[7:2] == 6'h18 && cfg_be_i[1];
  a_period_calc: assert property (frame_period_o == 16'he860 + {frame_adj_o, 4'h0})
    else $error("bad period");
  a_release_fixed: assert property (r |=> cfg_rdata_o[7:0] == 8'h20)
    else $error("bad release");
  a_adj_read: assert property (r |=> cfg_rdata_o[15:8] == {2'b00, $past(frame_adj_o)})
    else $error("bad adjust read");
  a_adj_write: assert property (u |=> frame_adj_o == $past(w))
    else $error("adjust not taken");
  a_adj_holds: assert property (!u |=> $stable(frame_adj_o))
    else $error("adjust moved");
  a_wake_inert: assert property (cfg_wr_i && !cfg_be_i[1] |=> $stable(frame_period_o))
    else $error("period moved");
  a_cap_pointer: assert property (cfg_rd_i && cfg_addr_i[7:2] == 6'h0d |=> cfg_rdata_o == 32'h0000_00dc)
    else $error("bad pointer");
  a_cap_header: assert property (cfg_rd_i && cfg_addr_i[7:2] == 6'h37 |=> cfg_rdata_o == 32'h0000_0001)
    else $error("bad header");
endmodule
bind ecx_cfg_extras ecx_cfg_props p (.*);

/* verification/ecx_host_model.sv */
`timescale 1ns/10ps
module ecx_host_model
(
  input  wire        mclk_i,
  input  wire [32:0] ans_i,
  output reg  [45:0] req_o,
  output reg         tick_o
);
  initial req_o = '0;
  initial tick_o = 1'b0;
  always @(posedge mclk_i) tick_o <= ~tick_o;
  // Request held until its taking edge; answer stands one cycle only
  task xfer(input w, input [7:0] a, input [35:0] d, output [32:0] r);
  begin
    @(posedge mclk_i);
    req_o <= {!w, w, a, d};
    @(posedge mclk_i);
    req_o[45:44] <= 2'b00;
    @(posedge mclk_i);
    r = ans_i;
  end
  endtask
endmodule

/* verification/ecx_cfg_extras_bench.sv */
`timescale 1ns/10ps
module ecx_cfg_extras_bench;
  reg mclk = 0;
  reg rst = 1;
  wire tick;
  wire [45:0] q;
  wire [32:0] ans;
  wire [15:0] per;
  wire [5:0] adj;
  wire sof;
  reg [32:0] r;
  integer mismatches = 0;
  integer num_checks = 0;
  always #20 mclk = ~mclk;
  ecx_host_model host (.mclk_i(mclk), .ans_i(ans), .req_o(q), .tick_o(tick));
  ecx_cfg_extras uut (.mclk_i(mclk), .sys_rst_i(rst), .cfg_rd_i(q[45]), .cfg_wr_i(q[44]), .cfg_addr_i(q[43:36]),
    .cfg_be_i(q[35:32]), .cfg_wdata_i(q[31:0]), .bit_tick_i(tick), .cfg_rdata_o(ans[31:0]), .cfg_hit_o(ans[32]),
    .frame_adj_o(adj), .frame_period_o(per), .sof_o(sof));
  task chk(input [32:0] g, e);
  begin
    num_checks = num_checks + 1;
    if (g !== e)
    begin
      mismatches = mismatches + 1;
      $display("wrong value %0t got %h want %h", $time, g, e);
    end
  end
  endtask
  task rd(input [7:0] a, input [32:0] e);
  begin
    host.xfer(0, a, 36'h0, r);
    chk(r, e);
  end
  endtask
  task close_out;
  begin
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  initial
  begin
    #20000;
    mismatches = mismatches + 1;
    close_out;
  end
  initial
  begin
    repeat (6) @(posedge mclk);
    rst <= 0;
    chk({17'h0_0000, per}, 33'h0_0000_ea60);
    chk({27'h0, adj}, 33'h0_0000_0020);
    rd(8'h60, 33'h1_0007_2020);
    rd(8'h34, 33'h1_0000_00dc);
    rd(8'hdc, 33'h1_0000_0001);
    rd(8'he0, 33'h0_0000_0000);
    host.xfer(1, 8'h60, 36'hf_1234_3f55, r);
    chk(r, 33'h1_0000_0000);
    host.xfer(1, 8'h60, 36'hc_abcd_0000, r);
    chk(r, 33'h1_0000_0000);
    host.xfer(1, 8'hdc, 36'hf_ffff_ffff, r);
    chk(r, 33'h1_0000_0000);
    rd(8'h60, 33'h1_abcd_3f20);
    chk({17'h0_0000, per}, 33'h0_0000_ec50);
    chk({27'h0, adj}, 33'h0_0000_003f);
    chk({32'h0000_0000, sof}, 33'h0_0000_0000);
    rd(8'hdc, 33'h1_0000_0001);
    close_out;
  end
endmodule
